/* tsw_defines.svh */
/*
 * Constants of the time/space switch: frame timing, memory sizes,
 * host opcodes and reset values.
 * Assumes it is included by bare name into the package, whose macros the modules then use.
 */
`ifndef TSW_DEFINES_SVH
`define TSW_DEFINES_SVH

// frame shape
`define TSW_LINES 8
`define TSW_SLOTS 32
`define TSW_MCLK_KHZ 4096
`define TSW_CORE_KHZ 10000
`define TSW_MCLK_PER_FRAME (2 * 8 * 32)
`define TSW_SLOT_DELAY 5'h02
`define TSW_LAST_BIT 3'h7
`define TSW_SLOT0_LAST_CNT 9'h00f
// buffering and stack
`define TSW_FIFO_DEPTH 16
`define TSW_STACK_MAX 3'h4
// host opcodes and their data byte counts
`define TSW_OP_CONNECT 5'h01
`define TSW_OP_DISCONNECT 5'h02
`define TSW_OP_INSERT 5'h03
`define TSW_OP_READ_CM 5'h04
`define TSW_OP_READ_DM 5'h05
`define TSW_LEN_FOUR 3'h4
`define TSW_LEN_TWO 3'h2
// reset and idle values
`define TSW_CM_RESET 9'h000
`define TSW_CM_IDLE 9'h1ff
`define TSW_DR_IDLE 1'b1
`define TSW_OD_LOW 1'b0
`endif

/* tsw_pkg.sv */
/*
 * Types shared by the switch modules.
 * Assumes tsw_defines.svh is on the include path.
 */
package tsw_pkg;
	`include "tsw_defines.svh"
	// one host byte as it travels through the write buffer
	typedef struct packed
	{
		logic cd;
		logic [4:0] data;
	} tsw_hbyte_s;
	// connection memory entry: message flag plus pointer or byte
	typedef logic [8:0] tsw_cm_t;
	// command executor states
	typedef enum logic [1:0]
	{
		TSW_ST_INIT = 2'b00,
		TSW_ST_RUN = 2'b01,
		TSW_ST_ERR = 2'b10
	} tsw_state_e;
endpackage : tsw_pkg

/* tsw_edge.sv */
/*
 * Edge detector for a pin already synchronous to core_clk.
 * Assumes the input is glitch free at the core clock rate.
 */
`timescale 1ns/100ps
module tsw_edge import tsw_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// level in, pulses out
	input wire logic sig,
	output logic rise,
	output logic fall
);
	logic prev_r; // level seen one cycle ago
	logic prev_nxt;

	// next value is simply the current level
	always_comb
	begin
		prev_nxt = sig;
	end

	always_ff @(posedge core_clk)
	begin
		// following the pin during reset keeps a high idle pin from
		// showing a false rise at release
		if (reset)
			prev_r <= sig;
		else
			prev_r <= prev_nxt;
	end

	assign rise = sig & ~prev_r;
	assign fall = ~sig & prev_r;
endmodule : tsw_edge

/* tsw_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/100ps
module tsw_fifo import tsw_pkg::*;
#(
	parameter int WIDTH = 6,
	parameter int DEPTH = `TSW_FIFO_DEPTH
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH]; // storage, no reset needed
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // pointers
	logic [AW:0] cnt_r, cnt_nxt; // fill level
	logic push, pop;

	assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// pointer and level update
	always_comb
	begin
		wp_nxt = push ? wp_r + AW'(1) : wp_r;
		rp_nxt = pop ? rp_r + AW'(1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage write
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
endmodule : tsw_fifo

/* tsw_switch.sv */
/*
 * Time/space switch: eight serial input lines stored per frame in a
 * data memory, eight open-drain output lines fed through a connection
 * memory, and a strobe-driven host port with a buffered command path.
 * Assumes all pins are synchronous to core_clk and that the master
 * clock pin toggles slower than half the core clock rate.
 */
`timescale 1ns/100ps
module tsw_switch import tsw_pkg::*;
#(
	parameter int FIFO_DEPTH = `TSW_FIFO_DEPTH
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// frame timing pins
	input wire logic mclk_in,
	input wire logic frame_sync_in,
	input wire logic init_n,
	// serial trunks
	input wire logic [7:0] serial_in_line,
	output logic [7:0] serial_out_line_o,
	output logic [7:0] serial_out_line_oe,
	// host bus
	input wire logic [7:0] bus_data_in,
	output logic [7:0] bus_data_o,
	output logic bus_data_oe,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic ctrl_data_sel,
	input wire logic select_n_first,
	input wire logic select_n_second,
	// cascade address match
	input wire logic match_in_a,
	input wire logic match_ref_a,
	input wire logic match_in_b,
	input wire logic match_ref_b,
	// handshake
	output logic handshake_ready_out
);
	// edge pulses
	logic mclk_rise, sync_rise, wr_rise, rd_fall;
	// frame counter: master clock rising edges since frame start
	logic [8:0] cnt_r, cnt_nxt;
	logic in_ev, out_ev, slot0_end;
	logic [4:0] out_slot;
	// initialization
	logic init_r, init_nxt, init_req_r, init_req_nxt;
	// memories
	logic [255:0][7:0] dm_r, dm_nxt; // one byte per input channel
	logic [255:0][8:0] cm_r, cm_nxt; // one entry per output channel
	wire [7:0] in_byte [8]; // byte completing on each line
	wire [7:0] out_bit; // current bit of each output line
	// host write path
	logic sel;
	tsw_hbyte_s wlat_r, wlat_nxt;
	logic wsel_r, wsel_nxt;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	tsw_hbyte_s fifo_in_data, fifo_out_data;
	logic fifo_in_valid;
	// executor
	tsw_state_e st_r, st_nxt;
	logic [3:0][4:0] stk_r, stk_nxt; // stk[0] is the newest byte
	logic [2:0] scnt_r, scnt_nxt;
	logic [4:0] op_r, op_nxt;
	logic [7:0] or1_r, or1_nxt;
	logic cm9_r, cm9_nxt;
	logic [7:0] or2, addr_lo, addr_hi;
	logic cm_we;
	logic [7:0] cm_wa;
	tsw_cm_t cm_wd;
	// pin registers
	logic [7:0] sout_oe_nxt, bus_o_nxt;
	logic bus_oe_nxt, dr_nxt;

	tsw_edge u_mclk (.core_clk(core_clk), .reset(reset), .sig(mclk_in),
		.rise(mclk_rise), .fall());
	tsw_edge u_sync (.core_clk(core_clk), .reset(reset), .sig(frame_sync_in),
		.rise(sync_rise), .fall());
	tsw_edge u_wr (.core_clk(core_clk), .reset(reset), .sig(write_n),
		.rise(wr_rise), .fall());
	tsw_edge u_rd (.core_clk(core_clk), .reset(reset), .sig(read_n),
		.rise(), .fall(rd_fall));

	// odd count means mid cell; boundary on every second edge
	assign in_ev = mclk_rise & ~cnt_r[0] & ~sync_rise;
	assign out_ev = sync_rise | (mclk_rise & cnt_r[0]);
	assign slot0_end = mclk_rise & ~sync_rise & (cnt_r == `TSW_SLOT0_LAST_CNT);
	assign out_slot = cnt_nxt[8:4] - `TSW_SLOT_DELAY;

	// frame counter, restarted by the sync rising edge
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (sync_rise)
			cnt_nxt = '0;
		else if (mclk_rise)
			cnt_nxt = cnt_r + 9'h001;
	end

	// init request caught anywhere in slot 0, acted on at its end
	always_comb
	begin
		init_nxt = init_r;
		init_req_nxt = init_req_r;
		if (slot0_end)
		begin
			init_nxt = init_req_r | ~init_n;
			init_req_nxt = 1'b0;
		end
		else if (cnt_r[8:4] == 5'h00 && !init_n)
			init_req_nxt = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cnt_r <= '0;
			init_r <= 1'b1; // power-up holds init until the first slot 0 ends
			init_req_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			init_r <= init_nxt;
			init_req_r <= init_req_nxt;
		end
	end

	// per-line serial converters
	for (genvar l = 0; l < 8; l++)
	begin : gen_lane
		logic [7:0] in_sh_r, in_sh_nxt, out_sh_r, out_sh_nxt;
		tsw_cm_t ent;
		logic [7:0] src;
		assign ent = cm_r[{3'(l), out_slot}];
		// message byte or stored input channel
		assign src = ent[8] ? ent[7:0] : dm_r[ent[7:0]];
		assign in_byte[l] = {in_sh_r[6:0], serial_in_line[l]};
		assign out_bit[l] = out_sh_r[7];
		// shift in at mid cell, load or shift out at boundary
		always_comb
		begin
			in_sh_nxt = in_ev ? in_byte[l] : in_sh_r;
			out_sh_nxt = out_sh_r;
			if (out_ev)
				out_sh_nxt = (cnt_nxt[3:1] == 3'h0) ? src : {out_sh_r[6:0], 1'b1};
		end
		always_ff @(posedge core_clk)
		begin
			if (reset)
			begin
				in_sh_r <= 8'hff;
				out_sh_r <= 8'hff;
			end
			else
			begin
				in_sh_r <= in_sh_nxt;
				out_sh_r <= out_sh_nxt;
			end
		end
	end

	// data memory: each line writes its slot after the last bit
	always_comb
	begin
		dm_nxt = dm_r;
		if (in_ev && cnt_r[3:1] == `TSW_LAST_BIT)
			for (int l = 0; l < 8; l++)
				dm_nxt[{3'(l), cnt_r[8:4]}] = in_byte[l];
	end

	// connection memory: init clears all, executor writes one
	always_comb
	begin
		cm_nxt = cm_r;
		if (init_r)
			cm_nxt = '0;
		else if (cm_we)
			cm_nxt[cm_wa] = cm_wd;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			dm_r <= '0;
			cm_r <= '0;
		end
		else
		begin
			dm_r <= dm_nxt;
			cm_r <= cm_nxt;
		end
	end

	// fully selected: both selects low and both pairs matching
	assign sel = ~select_n_first & ~select_n_second
		& (match_in_a == match_ref_a) & (match_in_b == match_ref_b);
	assign fifo_in_valid = wr_rise & wsel_r;
	assign fifo_in_data = wlat_r;
	assign fifo_out_ready = ~init_r; // executor stalls during init

	// latch bus while strobe low; last value is pushed at rising edge
	always_comb
	begin
		wlat_nxt = wlat_r;
		wsel_nxt = wsel_r;
		if (!write_n)
		begin
			wlat_nxt.cd = ctrl_data_sel;
			wlat_nxt.data = bus_data_in[4:0];
			wsel_nxt = sel & read_n; // both strobes low is ignored
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			wlat_r <= '0;
			wsel_r <= 1'b0;
		end
		else
		begin
			wlat_r <= wlat_nxt;
			wsel_r <= wsel_nxt;
		end
	end

	// buffer absorbs host bursts while the executor is held in init
	tsw_fifo #(.WIDTH($bits(tsw_hbyte_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign addr_lo = {stk_r[1][2:0], stk_r[0]};
	assign addr_hi = {stk_r[3][2:0], stk_r[2]};
	assign or2 = {st_r == TSW_ST_ERR, init_r, cm9_r, op_r};

	// executor: data bytes stack up, an opcode runs or is refused
	always_comb
	begin
		st_nxt = st_r;
		stk_nxt = stk_r;
		scnt_nxt = scnt_r;
		op_nxt = op_r;
		or1_nxt = or1_r;
		cm9_nxt = cm9_r;
		cm_we = 1'b0;
		cm_wa = addr_lo;
		cm_wd = `TSW_CM_IDLE;
		if (init_r)
		begin
			st_nxt = TSW_ST_INIT;
			scnt_nxt = '0;
		end
		else if (fifo_out_valid)
		begin
			if (!fifo_out_data.cd)
			begin
				stk_nxt = {stk_r[2:0], fifo_out_data.data};
				if (scnt_r != `TSW_STACK_MAX)
					scnt_nxt = scnt_r + 3'h1;
			end
			else
			begin
				scnt_nxt = '0;
				st_nxt = TSW_ST_RUN;
				op_nxt = fifo_out_data.data;
				case (fifo_out_data.data)
					`TSW_OP_CONNECT:
					begin
						cm_we = (scnt_r == `TSW_LEN_FOUR);
						cm_wd = {1'b0, addr_hi};
					end
					`TSW_OP_DISCONNECT:
						cm_we = (scnt_r == `TSW_LEN_TWO);
					`TSW_OP_INSERT:
					begin
						cm_we = (scnt_r == `TSW_LEN_FOUR);
						cm_wa = addr_hi;
						cm_wd = {1'b1, stk_r[1][3:0], stk_r[0][3:0]};
					end
					`TSW_OP_READ_CM:
					begin
						or1_nxt = cm_r[addr_lo][7:0];
						cm9_nxt = cm_r[addr_lo][8];
					end
					`TSW_OP_READ_DM:
						or1_nxt = dm_r[addr_lo];
					default:
						st_nxt = TSW_ST_ERR;
				endcase
				if (fifo_out_data.data inside {`TSW_OP_CONNECT, `TSW_OP_INSERT})
				begin
					if (scnt_r != `TSW_LEN_FOUR)
						st_nxt = TSW_ST_ERR;
				end
				else if (scnt_r != `TSW_LEN_TWO)
					st_nxt = TSW_ST_ERR;
				// refused opcode leaves memory and registers alone
				if (st_nxt == TSW_ST_ERR)
				begin
					op_nxt = op_r;
					or1_nxt = or1_r;
					cm9_nxt = cm9_r;
					cm_we = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_r <= TSW_ST_INIT;
			stk_r <= '0;
			scnt_r <= '0;
			op_r <= '0;
			or1_r <= '0;
			cm9_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			stk_r <= stk_nxt;
			scnt_r <= scnt_nxt;
			op_r <= op_nxt;
			or1_r <= or1_nxt;
			cm9_r <= cm9_nxt;
		end
	end

	// pin registers: open drain lines, host bus, handshake
	always_comb
	begin
		sout_oe_nxt = init_r ? 8'h00 : ~out_bit;
		bus_o_nxt = bus_data_o;
		if (rd_fall && sel && write_n)
			bus_o_nxt = ctrl_data_sel ? or2 : or1_r;
		bus_oe_nxt = ~read_n & write_n & sel & ~init_r;
		dr_nxt = ~(init_r | ~fifo_in_ready | (st_r == TSW_ST_ERR));
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			serial_out_line_o <= {8{`TSW_OD_LOW}};
			serial_out_line_oe <= 8'h00;
			bus_data_o <= 8'h00;
			bus_data_oe <= 1'b0;
			handshake_ready_out <= `TSW_DR_IDLE;
		end
		else
		begin
			serial_out_line_o <= {8{`TSW_OD_LOW}};
			serial_out_line_oe <= sout_oe_nxt;
			bus_data_o <= bus_o_nxt;
			bus_data_oe <= bus_oe_nxt;
			handshake_ready_out <= dr_nxt;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_slot0_low;
		slot0_end && !init_n;
	endsequence
	sequence s_init_frame;
		init_r [*8];
	endsequence

	od_never_high_a: assert property (serial_out_line_o == 8'h00)
		else $error("serial output value not low");
	init_quiet_a: assert property (init_r |=> (serial_out_line_oe == 8'h00 && !bus_data_oe))
		else $error("drivers active during init");
	init_clear_a: assert property (init_r |=> (cm_r == '0))
		else $error("connection memory not cleared");
	init_extend_a: assert property (s_slot0_low |=> s_init_frame)
		else $error("init not held after low sample");
	frame_start_a: assert property (sync_rise |=> (cnt_r == 9'h000))
		else $error("frame counter not restarted");
	bit_cell_a: assert property ($changed(gen_lane[0].out_sh_r) |-> $past(out_ev))
		else $error("output shifted off a bit boundary");
	full_dr_a: assert property (!fifo_in_ready |=> !handshake_ready_out)
		else $error("handshake high while buffer full");
	low_five_a: assert property (fifo_in_valid |-> (fifo_in_data.data == $past(bus_data_in[4:0])))
		else $error("pushed byte differs from bus");
	read_mux_a: assert property ((rd_fall && sel && write_n && !ctrl_data_sel)
		|=> (bus_data_o == $past(or1_r)))
		else $error("memory register not on bus");
	unsel_drop_a: assert property ((select_n_first && !write_n) ##1 wr_rise |-> !fifo_in_valid)
		else $error("write taken while deselected");
	// a faster master clock would merge levels in the edge sampler
	mclk_rate_a: assert property (mclk_rise |=> !mclk_rise)
		else $error("master clock too fast for core sampler");
endmodule : tsw_switch

/* tsw_trunk_model.sv */
/*
 * Trunk-side model: master clock, frame sync and eight serial input
 * lines, plus the pull-up that resolves the open-drain outputs.
 * Assumes the core clock runs four times as fast as the master clock.
 */
`timescale 1ns/100ps
module tsw_trunk_model import tsw_pkg::*;
(
	// core timing reference
	input wire logic core_clk,
	// frame timing and serial inputs to the switch
	output logic mclk_in,
	output logic frame_sync_in,
	output logic [7:0] serial_in_line,
	// open-drain outputs and their resolved wire levels
	input wire logic [7:0] serial_out_line_o,
	input wire logic [7:0] serial_out_line_oe,
	output logic [7:0] trunk_level
);
	logic [1:0] ph_r = 2'h0; // core cycles within one master period
	logic [8:0] fc_r = 9'h1ff; // master rises since frame start
	// master clock runs free; four core cycles keep the switch's sampler safe
	always @(posedge core_clk)
	begin
		#10;
		if (ph_r == 2'h1)
			fc_r = fc_r + 9'h001;
		ph_r = ph_r + 2'h1;
	end
	assign mclk_in = ph_r[1];
	// sync rises half a master period after the frame's first rise
	assign frame_sync_in = (fc_r == 9'h000) && !ph_r[1];
	// even lines high in odd slots, odd lines the opposite
	assign serial_in_line = {4{~fc_r[4], fc_r[4]}};
	// pull-up: a released line reads high
	assign trunk_level = ~serial_out_line_oe | serial_out_line_o;
endmodule : tsw_trunk_model

/* tsw_testbench.sv */
/*
 * Bench for the switch: command table with read-back, then serial,
 * refusal, error and reset-with-init cases.
 * Assumes tsw_pkg, tsw_switch and tsw_trunk_model are compiled first.
 */
`timescale 1ns/100ps
module testbench import tsw_pkg::*;
;
	// one command, the read-back that follows it and the masked answers
	typedef struct packed
	{
		logic [4:0] op;
		logic [2:0] n;
		logic [31:0] d;
		logic [4:0] rop;
		logic [15:0] ra;
		logic [7:0] e1, m1, e2, m2;
	} tsw_row_s;
	// pins driven by the bench
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic init_n = 1'b1;
	logic write_n = 1'b1;
	logic read_n = 1'b1;
	logic ctrl_data_sel = 1'b0;
	logic sel_n1 = 1'b0;
	logic sel_n2 = 1'b0;
	logic [1:0] m_in = 2'b10;
	logic [1:0] m_ref = 2'b10;
	logic [7:0] host_d = 8'h00;
	logic host_en = 1'b0;
	// switch and model outputs
	logic mclk_in, frame_sync_in, bus_data_oe, handshake_ready_out;
	logic [7:0] serial_in_line, serial_out_line_o, serial_out_line_oe;
	logic [7:0] bus_data_o, trunk_level, bus_w, v;
	logic [3:0] pat;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	// serial bytes only trusted in bits 5..2, slot edges may slip a bit
	tsw_row_s rows [6] = '{
		'{5'h01, 3'h4, 32'h03060205, 5'h04, 16'h0205, 8'h66, 8'hff, 8'h04, 8'hff},
		'{5'h03, 3'h4, 32'h04090a05, 5'h04, 16'h0409, 8'ha5, 8'hff, 8'h24, 8'hff},
		'{5'h01, 3'h4, 32'he6fee7ff, 5'h04, 16'h071f, 8'hde, 8'hff, 8'h04, 8'hff},
		'{5'h02, 3'h2, 32'h071f0000, 5'h04, 16'h071f, 8'hff, 8'hff, 8'h24, 8'hff},
		'{5'h00, 3'h0, 32'h0, 5'h05, 16'h0104, 8'h3c, 8'h3c, 8'h05, 8'hdf},
		'{5'h00, 3'h0, 32'h0, 5'h05, 16'h0004, 8'h00, 8'h3c, 8'h05, 8'hdf}};
	// bus wire: switch, host, else the inverse of the last host value
	assign bus_w = bus_data_oe ? bus_data_o : (host_en ? host_d : ~host_d);
	always #50 core_clk = ~core_clk;
	tsw_switch dut
	(
		.core_clk(core_clk), .reset(reset), .mclk_in(mclk_in),
		.frame_sync_in(frame_sync_in), .init_n(init_n), .serial_in_line(serial_in_line),
		.serial_out_line_o(serial_out_line_o), .serial_out_line_oe(serial_out_line_oe),
		.bus_data_in(bus_w), .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe),
		.write_n(write_n), .read_n(read_n), .ctrl_data_sel(ctrl_data_sel),
		.select_n_first(sel_n1), .select_n_second(sel_n2),
		.match_in_a(m_in[1]), .match_ref_a(m_ref[1]), .match_in_b(m_in[0]),
		.match_ref_b(m_ref[0]), .handshake_ready_out(handshake_ready_out)
	);
	tsw_trunk_model model
	(
		.core_clk(core_clk), .mclk_in(mclk_in), .frame_sync_in(frame_sync_in),
		.serial_in_line(serial_in_line), .serial_out_line_o(serial_out_line_o),
		.serial_out_line_oe(serial_out_line_oe), .trunk_level(trunk_level)
	);
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one write strobe; data held past the edge that sees the strobe rise
	task automatic wr(input logic cd, input logic [7:0] d);
		@(posedge core_clk);
		#10;
		ctrl_data_sel = cd;
		host_d = d;
		host_en = 1'b1;
		write_n = 1'b0;
		@(posedge core_clk);
		#10;
		write_n = 1'b1;
		@(posedge core_clk);
		#10;
		host_en = 1'b0;
	endtask : wr
	// data bytes then opcode, then room for the executor
	task automatic cmd(input logic [4:0] op, input logic [2:0] n, input logic [31:0] d);
		for (int i = 0; i < 4; i++)
			if (i < n)
				wr(1'b0, d[31 - 8 * i -: 8]);
		wr(1'b1, {3'h0, op});
		repeat (6) @(posedge core_clk);
	endtask : cmd
	// one read strobe, bus enable checked while low and after release
	task automatic rd(input logic cd, input logic oe_exp, output logic [7:0] r);
		@(posedge core_clk);
		#10;
		ctrl_data_sel = cd;
		read_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#10;
		chk({7'h0, bus_data_oe}, {7'h0, oe_exp});
		r = bus_w;
		read_n = 1'b1;
		repeat (2) @(posedge core_clk);
		#10;
		chk({7'h0, bus_data_oe}, 8'h00);
	endtask : rd
	// sample a trunk mid-cell, MSB first, at the odd master counts
	task automatic cap(input int ln, input int sl, output logic [7:0] r);
		for (int b = 0; b < 8; b++)
		begin
			@(posedge core_clk);
			while (model.fc_r !== 9'(sl * 16 + 2 * b + 1))
				@(posedge core_clk);
			r[7 - b] = trunk_level[ln];
		end
	endtask : cap
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// ceiling far above the roughly 11k cycles the sequence needs
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			error_cnt = error_cnt + 1;
			wrap_up();
		end
	end
	initial
	begin
		repeat (8) @(posedge core_clk);
		#10;
		reset = 1'b0;
		// init flag pulls the handshake low from the first edge on
		repeat (2) @(posedge core_clk);
		#10;
		chk({7'h0, handshake_ready_out}, 8'h00);
		// first init ends at a slot 0 with the init pin high; a sync then
		// aligns the switch's frame count with the model's
		@(posedge frame_sync_in);
		for (int i = 0; i < 3000 && handshake_ready_out !== 1'b1; i++)
			@(posedge core_clk);
		#10;
		chk({7'h0, handshake_ready_out}, 8'h01);
		foreach (rows[i])
		begin
			if (rows[i].n != 3'h0)
				cmd(rows[i].op, rows[i].n, rows[i].d);
			cmd(rows[i].rop, 3'h2, {rows[i].ra, 16'h0000});
			rd(1'b0, 1'b1, v);
			chk(v & rows[i].m1, rows[i].e1);
			rd(1'b1, 1'b1, v);
			chk(v & rows[i].m2, rows[i].e2);
		end
		$display("test table done");
		// message byte and switched byte on the trunks, two slots late
		cap(4, 11, v);
		chk(v, 8'ha5);
		cap(2, 7, v);
		chk(v & 8'h3c, 8'h3c);
		chk(serial_out_line_o, 8'h00);
		$display("test trunks done");
		// each of the four selection terms missing in turn
		for (int p = 0; p < 4; p++)
		begin
			pat = 4'h8 >> p;
			sel_n1 = pat[3];
			sel_n2 = pat[2];
			m_in = 2'b10 ^ pat[1:0];
			cmd(5'h01, 3'h4, 32'h05010003);
			rd(1'b0, 1'b0, v);
			sel_n1 = 1'b0;
			sel_n2 = 1'b0;
			m_in = 2'b10;
			cmd(5'h04, 3'h2, 32'h00030000);
			rd(1'b0, 1'b1, v);
			chk(v, 8'h00);
		end
		// short byte count: flagged, memory untouched, cleared by a good opcode
		cmd(5'h01, 3'h2, 32'h00030000);
		chk({7'h0, handshake_ready_out}, 8'h00);
		cmd(5'h04, 3'h2, 32'h00030000);
		chk({7'h0, handshake_ready_out}, 8'h01);
		rd(1'b0, 1'b1, v);
		chk(v, 8'h00);
		// unknown opcode flagged; a read with a wrong count keeps the register
		cmd(5'h1f, 3'h2, 32'h02050000);
		chk({7'h0, handshake_ready_out}, 8'h00);
		cmd(5'h04, 3'h3, 32'h00020500);
		rd(1'b0, 1'b1, v);
		chk(v, 8'h00);
		$display("test refusal done");
		// second reset with the init pin low; writes buffered meanwhile
		reset = 1'b1;
		init_n = 1'b0;
		repeat (8) @(posedge core_clk);
		#10;
		reset = 1'b0;
		repeat (2) @(posedge core_clk);
		chk({7'h0, handshake_ready_out}, 8'h00);
		for (int i = 1; i < 4; i++)
			cmd(5'h01, 3'h4, {8'h01, 8'(i), 8'h05, 8'(i)});
		// sixteenth entry is a bare opcode, the seventeenth must be refused
		wr(1'b1, 8'h02);
		wr(1'b0, 8'h11);
		repeat (2) @(posedge frame_sync_in);
		repeat (300) @(posedge core_clk);
		#10;
		init_n = 1'b1;
		repeat (1000) @(posedge core_clk);
		chk({7'h0, handshake_ready_out}, 8'h00);
		chk(serial_out_line_oe, 8'h00);
		rd(1'b1, 1'b0, v);
		repeat (1200) @(posedge core_clk);
		rd(1'b1, 1'b1, v);
		chk(v & 8'hc0, 8'h80);
		cmd(5'h04, 3'h2, 32'h05030000);
		rd(1'b0, 1'b1, v);
		chk(v, 8'h23);
		cmd(5'h04, 3'h2, 32'h02050000);
		rd(1'b0, 1'b1, v);
		chk(v, 8'h00);
		chk({7'h0, handshake_ready_out}, 8'h01);
		$display("test reset done");
		wrap_up();
	end
endmodule : testbench
